// [core/tcio_top.sv]
// Notes on behaviour
// - Bit 6 of AB control selects capture (1) or compare (0) for register B.
// - B compare match: 00 hold, 01 low, 10 high, 11 toggle pin B.
// - B capture edge: 00 rising, 01 falling, 1X both edges.
// - Bit 2 of AB control selects capture or compare for register A.
// - A compare match: 00 hold, 01 low, 10 high, 11 toggle pin A.
// - A capture edge: 00 rising, 01 falling, 1X both edges.
// - Bit 6 of CD control selects capture or compare for register D.
// - D compare match, bits 5:4: hold, low, high, toggle pin D.
// - D capture edge, bits 5:4: rising, falling, both.
// - Bit 2 of CD control selects capture or compare for register C.
// - C compare match, bits 1:0: hold, low, high, toggle pin C.
// - C capture edge, bits 1:0: rising, falling, both.
// - Bits 7 and 3 of both control registers read 1, ignore writes.
// - Selected capture edge loads counter into register and sets flag.
// - Compare equality sets the flag alongside the pin action.
//
// Our own choices: the address-and-strobe port and the address map.
`include "tcio_map.svh"
`timescale 1ns/1ns
`default_nettype none
module tcio_top (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	input wire logic [15:0] timer_up_counter,
	input wire logic timer_pin_a_in,
	input wire logic timer_pin_b_in,
	input wire logic timer_pin_c_in,
	input wire logic timer_pin_d_in,
	output logic timer_pin_a_out,
	output logic timer_pin_b_out,
	output logic timer_pin_c_out,
	output logic timer_pin_d_out,
	output logic timer_pin_a_oe,
	output logic timer_pin_b_oe,
	output logic timer_pin_c_oe,
	output logic timer_pin_d_oe,
	output logic irq
);
	tcio_pkg::tcio_bus_req_t req;
	logic [5:0] ab_q;
	logic [5:0] cd_q;
	logic [3:0] stat_q;
	logic [3:0] ien_q;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic [3:0] pin_in;
	logic [3:0] rise;
	logic [3:0] fall;
	logic [3:0] lvl;
	logic [3:0] evt;
	logic [3:0] pout;
	logic [3:0] gr_wr;
	logic [15:0] grv [4];
	tcio_pkg::tcio_chan_cfg_t cfg [4];

	function automatic logic [7:0] ctl_view(input logic [5:0] f);
		ctl_view = `TCIO_RSV_MASK | {1'b0, f[5:3], 1'b0, f[2:0]};
	endfunction : ctl_view

	assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
	assign pin_in = {timer_pin_d_in, timer_pin_c_in, timer_pin_b_in, timer_pin_a_in};
	wire sel_ab = (req.addr == `TCIO_OFF_IOCTL_AB);
	wire sel_cd = (req.addr == `TCIO_OFF_IOCTL_CD);
	wire sel_clr = (req.addr == `TCIO_OFF_IRQ_CLEAR);
	wire sel_ien = (req.addr == `TCIO_OFF_IRQ_ENABLE);
	assign gr_wr[0] = req.wr && (req.addr == `TCIO_OFF_GR_A);
	assign gr_wr[1] = req.wr && (req.addr == `TCIO_OFF_GR_B);
	assign gr_wr[2] = req.wr && (req.addr == `TCIO_OFF_GR_C);
	assign gr_wr[3] = req.wr && (req.addr == `TCIO_OFF_GR_D);
	wire [3:0] clr_bits = (req.wr && sel_clr) ? req.wdata[3:0] : 4'h0;

	assign cfg[0] = '{capture: ab_q[2], action: ab_q[1:0]};
	assign cfg[1] = '{capture: ab_q[5], action: ab_q[4:3]};
	assign cfg[2] = '{capture: cd_q[2], action: cd_q[1:0]};
	assign cfg[3] = '{capture: cd_q[5], action: cd_q[4:3]};

	always_comb begin
		rdata_d = 16'h0000;
		if (sel_ab) begin
			rdata_d = {8'h00, ctl_view(ab_q)};
		end else if (sel_cd) begin
			rdata_d = {8'h00, ctl_view(cd_q)};
		end else if (req.addr == `TCIO_OFF_GR_A) begin
			rdata_d = grv[0];
		end else if (req.addr == `TCIO_OFF_GR_B) begin
			rdata_d = grv[1];
		end else if (req.addr == `TCIO_OFF_GR_C) begin
			rdata_d = grv[2];
		end else if (req.addr == `TCIO_OFF_GR_D) begin
			rdata_d = grv[3];
		end else if (req.addr == `TCIO_OFF_COUNTER) begin
			rdata_d = timer_up_counter;
		end else if (req.addr == `TCIO_OFF_IRQ_STATUS) begin
			rdata_d = {12'h000, stat_q};
		end else if (sel_ien) begin
			rdata_d = {12'h000, ien_q};
		end else if (req.addr == `TCIO_OFF_PIN_STATE) begin
			rdata_d = {8'h00, lvl, pout};
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ab_q <= 6'h00;
			cd_q <= 6'h00;
			ien_q <= 4'h0;
			stat_q <= 4'h0;
			rdata_q <= 16'h0000;
		end else if (clk_en) begin
			if (req.wr && sel_ab) begin
				ab_q <= {req.wdata[6:4], req.wdata[2:0]};
			end
			if (req.wr && sel_cd) begin
				cd_q <= {req.wdata[6:4], req.wdata[2:0]};
			end
			if (req.wr && sel_ien) begin
				ien_q <= req.wdata[3:0];
			end
			stat_q <= (stat_q & ~clr_bits) | evt;
			rdata_q <= req.rd ? rdata_d : 16'h0000;
		end
	end

	for (genvar i = 0; i < 4; i++) begin : g_ch
		tcio_pin_sync u_sync (
			.clk(clk),
			.rst_b(rst_b),
			.clk_en(clk_en),
			.pin_in(pin_in[i]),
			.level(lvl[i]),
			.rise(rise[i]),
			.fall(fall[i])
		);
		tcio_channel u_chan (
			.clk(clk),
			.rst_b(rst_b),
			.clk_en(clk_en),
			.cfg(cfg[i]),
			.count(timer_up_counter),
			.gr_wr(gr_wr[i]),
			.gr_wdata(req.wdata),
			.pin_rise(rise[i]),
			.pin_fall(fall[i]),
			.gr_value(grv[i]),
			.pin_out(pout[i]),
			.event_pulse(evt[i])
		);
	end

	assign rdata = rdata_q;
	assign irq = |(stat_q & ien_q);
	assign timer_pin_a_out = pout[0];
	assign timer_pin_b_out = pout[1];
	assign timer_pin_c_out = pout[2];
	assign timer_pin_d_out = pout[3];
	// A pin is driven only while its channel is in compare mode.
	assign timer_pin_a_oe = !cfg[0].capture;
	assign timer_pin_b_oe = !cfg[1].capture;
	assign timer_pin_c_oe = !cfg[2].capture;
	assign timer_pin_d_oe = !cfg[3].capture;
endmodule : tcio_top
`default_nettype wire

// [core/tcio_map.svh]
`ifndef TCIO_MAP_SVH
`define TCIO_MAP_SVH
`define TCIO_ADDR_W 4
`define TCIO_OFF_IOCTL_AB 4'h0
`define TCIO_OFF_IOCTL_CD 4'h1
`define TCIO_OFF_GR_A 4'h2
`define TCIO_OFF_GR_B 4'h3
`define TCIO_OFF_GR_C 4'h4
`define TCIO_OFF_GR_D 4'h5
`define TCIO_OFF_COUNTER 4'h6
`define TCIO_OFF_IRQ_STATUS 4'h7
`define TCIO_OFF_IRQ_CLEAR 4'h8
`define TCIO_OFF_IRQ_ENABLE 4'h9
`define TCIO_OFF_PIN_STATE 4'hA
`define TCIO_BIT_HI_SEL 6
`define TCIO_BIT_HI_ACT 4
`define TCIO_BIT_LO_SEL 2
`define TCIO_BIT_LO_ACT 0
`define TCIO_RSV_MASK 8'h88
`define TCIO_CTL_RESET 8'h00
`define TCIO_GR_RESET 16'hFFFF
`endif

// [core/tcio_pkg.sv]
package tcio_pkg;
	typedef enum logic [1:0] {
		TCIO_ACT_NONE = 2'h0,
		TCIO_ACT_LOW = 2'h1,
		TCIO_ACT_HIGH = 2'h2,
		TCIO_ACT_TOGGLE = 2'h3
	} tcio_action_t;
	typedef struct packed {
		logic capture;
		logic [1:0] action;
	} tcio_chan_cfg_t;
	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} tcio_bus_req_t;
endpackage : tcio_pkg

// [core/tcio_pin_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module tcio_pin_sync (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic pin_in,
	output logic level,
	output logic rise,
	output logic fall
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic lvl_q;
	wire agree = (s2_q == s3_q);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			lvl_q <= 1'b0;
		end else if (clk_en) begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (agree) begin
				lvl_q <= s3_q;
			end
		end
	end
	assign level = lvl_q;
	assign rise = clk_en && agree && s3_q && !lvl_q;
	assign fall = clk_en && agree && !s3_q && lvl_q;
endmodule : tcio_pin_sync
`default_nettype wire

// [core/tcio_channel.sv]
`include "tcio_map.svh"
`timescale 1ns/1ns
`default_nettype none
module tcio_channel (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire tcio_pkg::tcio_chan_cfg_t cfg,
	input wire logic [15:0] count,
	input wire logic gr_wr,
	input wire logic [15:0] gr_wdata,
	input wire logic pin_rise,
	input wire logic pin_fall,
	output logic [15:0] gr_value,
	output logic pin_out,
	output logic event_pulse
);
	logic [15:0] gr_q;
	logic out_q;
	wire match = !cfg.capture && (count == gr_q);
	wire edge_hit = cfg.action[1] ? (pin_rise || pin_fall) : (cfg.action[0] ? pin_fall : pin_rise);
	wire cap = cfg.capture && edge_hit;
	logic out_d;
	always_comb begin
		out_d = out_q;
		case (cfg.action)
			tcio_pkg::TCIO_ACT_LOW: out_d = 1'b0;
			tcio_pkg::TCIO_ACT_HIGH: out_d = 1'b1;
			tcio_pkg::TCIO_ACT_TOGGLE: out_d = !out_q;
			default: out_d = out_q;
		endcase
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			gr_q <= `TCIO_GR_RESET;
			out_q <= 1'b0;
		end else if (clk_en) begin
			if (cap) begin
				gr_q <= count;
			end else if (gr_wr) begin
				gr_q <= gr_wdata;
			end
			if (match) begin
				out_q <= out_d;
			end
		end
	end
	assign gr_value = gr_q;
	assign pin_out = out_q;
	assign event_pulse = clk_en && (cap || match);
endmodule : tcio_channel
`default_nettype wire

// [verif/tcio_pin_model.sv]
`timescale 1ns/1ns
`default_nettype none
module tcio_pin_model (
	input wire logic [3:0] oe,
	input wire logic [3:0] out,
	input wire logic [3:0] drv,
	output logic [3:0] pin_in
);
	// A pin reads back the timer's drive while enabled, else the outside level.
	assign pin_in = (oe & out) | (~oe & drv);
endmodule : tcio_pin_model
`default_nettype wire

// [verif/tcio_chk_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
module tcio_chk (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] rdata,
	input wire logic [15:0] timer_up_counter,
	input wire logic timer_pin_a_out,
	input wire logic timer_pin_b_out,
	input wire logic timer_pin_a_oe,
	input wire logic timer_pin_b_oe,
	input wire logic timer_pin_c_oe,
	input wire logic timer_pin_d_oe
);
	logic [7:0] ab_q;
	logic [7:0] cd_q;
	logic [15:0] gra_q;
	logic [15:0] grb_q;
	function automatic logic nxt_pin(input logic [1:0] act, input logic prev);
		return act[1] ? (act[0] ? !prev : 1'b1) : (act[0] ? 1'b0 : prev);
	endfunction : nxt_pin
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ab_q <= 8'h00;
			cd_q <= 8'h00;
			gra_q <= 16'hFFFF;
			grb_q <= 16'hFFFF;
		end else if (wr && clk_en) begin
			if (addr == 4'h0) ab_q <= wdata[7:0];
			if (addr == 4'h1) cd_q <= wdata[7:0];
			if (addr == 4'h2) gra_q <= wdata;
			if (addr == 4'h3) grb_q <= wdata;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	rd_idle_a: assert property (clk_en && !rd |=> rdata == 16'h0000) else $error("rdata not idle");
	rsv_ones_a: assert property (rd && addr < 4'h2 |=> rdata[7] && rdata[3]) else $error("reserved bit low");
	oe_a_a: assert property (timer_pin_a_oe == !ab_q[2]) else $error("pin a enable wrong");
	oe_b_a: assert property (timer_pin_b_oe == !ab_q[6]) else $error("pin b enable wrong");
	oe_c_a: assert property (timer_pin_c_oe == !cd_q[2]) else $error("pin c enable wrong");
	oe_d_a: assert property (timer_pin_d_oe == !cd_q[6]) else $error("pin d enable wrong");
	cmp_a_a: assert property (clk_en && !ab_q[2] && timer_up_counter == gra_q
		|=> timer_pin_a_out == nxt_pin($past(ab_q[1:0]), $past(timer_pin_a_out))) else $error("pin a action wrong");
	cmp_b_a: assert property (clk_en && !ab_q[6] && timer_up_counter == grb_q
		|=> timer_pin_b_out == nxt_pin($past(ab_q[5:4]), $past(timer_pin_b_out))) else $error("pin b action wrong");
	hold_a_a: assert property (!ab_q[2] && timer_up_counter != gra_q |=> $stable(timer_pin_a_out))
		else $error("pin a moved");
endmodule : tcio_chk
bind tcio_top tcio_chk chk_u (
	.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.timer_up_counter(timer_up_counter), .timer_pin_a_out(timer_pin_a_out), .timer_pin_b_out(timer_pin_b_out),
	.timer_pin_a_oe(timer_pin_a_oe), .timer_pin_b_oe(timer_pin_b_oe), .timer_pin_c_oe(timer_pin_c_oe),
	.timer_pin_d_oe(timer_pin_d_oe));
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic clk_en = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] cnt = 16'h0000;
	logic [3:0] drv = 4'h0;
	logic [3:0] pin_in;
	logic [3:0] pin_out;
	logic [3:0] pin_oe;
	logic [15:0] rdata;
	logic irq;
	logic [1:0] acts [5] = '{2'h2, 2'h1, 2'h3, 2'h3, 2'h0};
	logic [4:0] exps = 5'b00101;
	int n_mismatch = 0;
	int comparisons = 0;
	int cycles = 0;
	always #5 clk = ~clk;
	tcio_top dut_u (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .timer_up_counter(cnt), .timer_pin_a_in(pin_in[0]), .timer_pin_b_in(pin_in[1]),
		.timer_pin_c_in(pin_in[2]), .timer_pin_d_in(pin_in[3]), .timer_pin_a_out(pin_out[0]),
		.timer_pin_b_out(pin_out[1]), .timer_pin_c_out(pin_out[2]), .timer_pin_d_out(pin_out[3]),
		.timer_pin_a_oe(pin_oe[0]), .timer_pin_b_oe(pin_oe[1]), .timer_pin_c_oe(pin_oe[2]),
		.timer_pin_d_oe(pin_oe[3]), .irq(irq));
	tcio_pin_model pins_u (.oe(pin_oe), .out(pin_out), .drv(drv), .pin_in(pin_in));
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : give_verdict
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : wr_reg
	task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 check(rdata, exp);
		@(posedge clk);
	endtask : rd_chk
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd_chk(4'h0, 16'h0088);
		rd_chk(4'h1, 16'h0088);
		wr_reg(4'h0, 16'h0077);
		rd_chk(4'h0, 16'h00FF);
		rd_chk(4'hB, 16'h0000);
		$display("register test done");
		wr_reg(4'h2, 16'h0010);
		wr_reg(4'h3, 16'h0010);
		wr_reg(4'h4, 16'h0010);
		wr_reg(4'h5, 16'h0010);
		for (int i = 0; i < 5; i++) begin
			wr_reg(4'h0, {8'h00, 2'b00, acts[i], 2'b00, acts[i]});
			wr_reg(4'h1, {8'h00, 2'b00, acts[i], 2'b00, acts[i]});
			cnt <= 16'h0010;
			@(posedge clk);
			cnt <= 16'h0000;
			repeat (5) @(posedge clk);
			rd_chk(4'hA, {8'h00, {8{exps[i]}}});
			check({12'h000, pin_out}, {12'h000, {4{exps[i]}}});
		end
		rd_chk(4'h7, 16'h000F);
		check({15'h0000, irq}, 16'h0000);
		wr_reg(4'h9, 16'h0001);
		check({15'h0000, irq}, 16'h0001);
		wr_reg(4'h8, 16'h0001);
		check({15'h0000, irq}, 16'h0000);
		rd_chk(4'h7, 16'h000E);
		wr_reg(4'h0, 16'h0033);
		wr_reg(4'h1, 16'h0033);
		clk_en <= 1'b0;
		cnt <= 16'h0010;
		repeat (4) @(posedge clk);
		clk_en <= 1'b1;
		cnt <= 16'h0000;
		@(posedge clk);
		check({12'h000, pin_out}, 16'h0000);
		rd_chk(4'h7, 16'h000E);
		wr_reg(4'h8, 16'h000F);
		rd_chk(4'h7, 16'h0000);
		$display("compare test done");
		wr_reg(4'h0, 16'h0054);
		wr_reg(4'h1, 16'h0054);
		cnt <= 16'h1234;
		drv <= 4'hF;
		repeat (8) @(posedge clk);
		rd_chk(4'h6, 16'h1234);
		rd_chk(4'h2, 16'h1234);
		rd_chk(4'h3, 16'h0010);
		rd_chk(4'h4, 16'h1234);
		rd_chk(4'h5, 16'h0010);
		cnt <= 16'h5678;
		drv <= 4'h0;
		repeat (8) @(posedge clk);
		rd_chk(4'h2, 16'h1234);
		rd_chk(4'h3, 16'h5678);
		rd_chk(4'h4, 16'h1234);
		rd_chk(4'h5, 16'h5678);
		wr_reg(4'h0, 16'h0077);
		wr_reg(4'h1, 16'h0066);
		cnt <= 16'h9ABC;
		drv <= 4'hF;
		repeat (8) @(posedge clk);
		rd_chk(4'h2, 16'h9ABC);
		rd_chk(4'h3, 16'h9ABC);
		rd_chk(4'h4, 16'h9ABC);
		rd_chk(4'h5, 16'h9ABC);
		rd_chk(4'h7, 16'h000F);
		check({15'h0000, irq}, 16'h0001);
		$display("capture test done");
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
